// File: rtl/acs_pkg.sv
/*
 * Shared constants of the conversion-cycle controller: result and word
 * layout, serial frame lengths, timing figures and the sequencer states.
 * Assumes a 20 MHz system clock; the cycle counts are derived from it.
 */
package acs_pkg;

    // ------------------------------------------------------------------
    // data layout
    // ------------------------------------------------------------------
    localparam int RES_W      = 16;
    localparam int RES_MSB    = RES_W - 1;
    localparam int WORD_W     = 4;
    localparam int KEY_HI_POS = 3;  // program_key_high_bit, first bit in
    localparam int KEY_LO_POS = 2;  // program_key_low_bit, second bit in
    localparam int RATE_POS   = 1;  // rate_select_bit, third bit in
    localparam int SLEEP_POS  = 0;  // reference_powerdown_bit, fourth bit in

    localparam logic [WORD_W-1:0] WORD_ALL_LOW  = 4'h0;
    localparam logic [WORD_W-1:0] WORD_ALL_HIGH = 4'hf;

    localparam logic [4:0] FALL_LAST = 5'h10;   // sixteenth falling edge
    localparam logic [2:0] RISE_LAST = 3'h4;    // fourth rising edge

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 50;
    localparam int CONV_SLOW_TIME_US = 4000;
    localparam int CONV_FAST_TIME_US = 1000;
    localparam int POR_TIME_US       = 500;

    localparam int CONV_SLOW_CYC = CONV_SLOW_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int CONV_FAST_CYC = CONV_FAST_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int POR_CYC       = POR_TIME_US * 1000 / CLK_PERIOD_NS;

    localparam int TMR_W = 17;
    localparam logic [TMR_W-1:0] TMR_ZERO = 17'h00000;
    localparam logic [TMR_W-1:0] TMR_ONE  = 17'h00001;

    // ------------------------------------------------------------------
    // sequencer states, gray along por -> convert -> nap -> dio
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ACS_POR     = 2'h0,
        ACS_CONVERT = 2'h1,
        ACS_NAP     = 2'h3,
        ACS_DIO     = 2'h2
    } acs_state_t;

endpackage

// File: rtl/acs_sync2.sv
/*
 * Two-flop synchroniser for one level.
 * Assumes d is asynchronous to clk; only the second flop is read outside.
 */
`timescale 1ns/1ps

module acs_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);

    typedef struct packed {
        logic meta;
        logic sync;
    } acs_sync_t;

    acs_sync_t s_q;
    acs_sync_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.meta = d;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '{meta: RST_VAL, sync: RST_VAL};
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.sync;

endmodule

// File: rtl/acs_ctrl.sv
/*
 * Conversion-cycle sequencer and serial port of a 16-bit converter.
 * Holds the power-on delay, times conversions, latches the result,
 * shifts it out on the serial clock and takes the 4-bit programming word.
 * Assumes: sys_rst stands for the internal power-on reset; result_in is
 * the analog core's result, valid when a conversion ends; sck is the
 * host's clock and only toggles while chip_sel_n is low.
 */
`timescale 1ns/1ps

module acs_ctrl #(
    parameter int unsigned CONV_SLOW_CYC = acs_pkg::CONV_SLOW_CYC,
    parameter int unsigned CONV_FAST_CYC = acs_pkg::CONV_FAST_CYC,
    parameter int unsigned POR_CYC       = acs_pkg::POR_CYC
) (
    input  wire logic                      ref_clk,
    input  wire logic                      sys_rst,
    input  wire logic [acs_pkg::RES_W-1:0] result_in,
    input  wire logic                      sck,
    input  wire logic                      chip_sel_n,
    input  wire logic                      sdi,
    output logic                           sdo,
    output logic                           sdo_oe_n,
    output logic                           converter_on,
    output logic                           reference_on,
    output logic                           conv_busy,
    output logic                           rate_fast,
    output logic                           ref_sleep_en
);

    // ------------------------------------------------------------------
    // cycle limits at counter width
    // ------------------------------------------------------------------
    localparam logic [acs_pkg::TMR_W-1:0] SLOW_LAST = acs_pkg::TMR_W'(CONV_SLOW_CYC - 1);
    localparam logic [acs_pkg::TMR_W-1:0] FAST_LAST = acs_pkg::TMR_W'(CONV_FAST_CYC - 1);
    localparam logic [acs_pkg::TMR_W-1:0] POR_LAST  = acs_pkg::TMR_W'(POR_CYC - 1);

    // ------------------------------------------------------------------
    // state of the system-clock side
    // ------------------------------------------------------------------
    typedef struct packed {
        acs_pkg::acs_state_t         state;
        logic [acs_pkg::TMR_W-1:0]   tmr;
        logic [acs_pkg::RES_W-1:0]   result;
        logic                        rate_fast;
        logic                        sleep_en;
        logic                        conv_on;
        logic                        ref_on;
        logic                        cs_prev;
        logic                        done_prev;
        logic                        word_prev;
    } acs_sys_t;

    // ------------------------------------------------------------------
    // state of the link side, one struct per clock edge
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]                  rise_cnt;
        logic [acs_pkg::WORD_W-1:0]  word;
        logic                        word_rdy;
    } acs_rise_t;

    typedef struct packed {
        logic [4:0]                  fall_cnt;
        logic                        done;
    } acs_fall_t;

    acs_sys_t  s_q;
    acs_sys_t  s_d;
    acs_rise_t r_q;
    acs_rise_t r_d;
    acs_fall_t f_q;
    acs_fall_t f_d;

    logic cs_n_s;
    logic done_s;
    logic word_s;

    // ------------------------------------------------------------------
    // crossings into the system clock
    // ------------------------------------------------------------------
    acs_sync2 #(
        .RST_VAL (1'b1)
    ) u_sync_cs (
        .clk (ref_clk),
        .rst (sys_rst),
        .d   (chip_sel_n),
        .q   (cs_n_s)
    );

    acs_sync2 #(
        .RST_VAL (1'b0)
    ) u_sync_done (
        .clk (ref_clk),
        .rst (sys_rst),
        .d   (f_q.done),
        .q   (done_s)
    );

    acs_sync2 #(
        .RST_VAL (1'b0)
    ) u_sync_word (
        .clk (ref_clk),
        .rst (sys_rst),
        .d   (r_q.word_rdy),
        .q   (word_s)
    );

    // ------------------------------------------------------------------
    // link side: rising edges take the programming word
    // ------------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        if (r_q.rise_cnt != acs_pkg::RISE_LAST) begin
            r_d.word     = {r_q.word[acs_pkg::WORD_W-2:0], sdi};
            r_d.rise_cnt = r_q.rise_cnt + 3'h1;
            r_d.word_rdy = (r_q.rise_cnt == acs_pkg::RISE_LAST - 3'h1);
        end
    end

    // chip select high clears the frame; no edge is expected outside one
    always_ff @(posedge sck or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------
    // link side: falling edges step the output bit
    // ------------------------------------------------------------------
    always_comb begin
        f_d = f_q;
        if (f_q.fall_cnt != acs_pkg::FALL_LAST) begin
            f_d.fall_cnt = f_q.fall_cnt + 5'h01;
            f_d.done     = (f_q.fall_cnt == acs_pkg::FALL_LAST - 5'h01);
        end
    end

    always_ff @(negedge sck or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

    // the result register is static for the whole data state, so the link
    // may read it directly; msb shows before any clock edge arrives
    always_comb begin
        sdo = 1'b0;
        if (f_q.fall_cnt != acs_pkg::FALL_LAST) begin
            sdo = s_q.result[4'(acs_pkg::RES_MSB) - f_q.fall_cnt[3:0]];
        end
    end

    assign sdo_oe_n = chip_sel_n;

    // ------------------------------------------------------------------
    // sequencer on the system clock
    // ------------------------------------------------------------------
    always_comb begin
        logic [acs_pkg::TMR_W-1:0] conv_last;
        logic                      cs_rise;
        logic                      done_rise;
        logic                      word_rise;
        logic [acs_pkg::WORD_W-1:0] w;

        conv_last = s_q.rate_fast ? FAST_LAST : SLOW_LAST;
        cs_rise   = cs_n_s & ~s_q.cs_prev;
        done_rise = done_s & ~s_q.done_prev;
        word_rise = word_s & ~s_q.word_prev;
        w         = r_q.word;

        s_d           = s_q;
        s_d.cs_prev   = cs_n_s;
        s_d.done_prev = done_s;
        s_d.word_prev = word_s;

        unique case (s_q.state)
            acs_pkg::ACS_POR: begin
                s_d.tmr = s_q.tmr + acs_pkg::TMR_ONE;
                if (s_q.tmr == POR_LAST) begin
                    s_d.tmr     = acs_pkg::TMR_ZERO;
                    s_d.state   = acs_pkg::ACS_CONVERT;
                    s_d.conv_on = 1'b1;
                end
            end
            acs_pkg::ACS_CONVERT: begin
                // no input leaves this state early
                s_d.tmr = s_q.tmr + acs_pkg::TMR_ONE;
                if (s_q.tmr == conv_last) begin
                    s_d.tmr     = acs_pkg::TMR_ZERO;
                    s_d.result  = result_in;
                    s_d.state   = acs_pkg::ACS_NAP;
                    s_d.conv_on = 1'b0;
                    if (s_q.sleep_en) begin
                        s_d.ref_on = 1'b0;
                    end
                end
            end
            acs_pkg::ACS_NAP: begin
                if (!cs_n_s) begin
                    s_d.state  = acs_pkg::ACS_DIO;
                    s_d.ref_on = 1'b1;
                end
            end
            acs_pkg::ACS_DIO: begin
                if (word_rise) begin
                    if (w[acs_pkg::KEY_HI_POS] && !w[acs_pkg::KEY_LO_POS]) begin
                        s_d.rate_fast = w[acs_pkg::RATE_POS];
                        s_d.sleep_en  = w[acs_pkg::SLEEP_POS];
                    end else if (w == acs_pkg::WORD_ALL_LOW) begin
                        s_d.rate_fast = 1'b0;
                        s_d.sleep_en  = 1'b0;
                    end else if (w == acs_pkg::WORD_ALL_HIGH) begin
                        s_d.rate_fast = 1'b1;
                        s_d.sleep_en  = 1'b0;
                    end
                end
                if (cs_rise || done_rise) begin
                    s_d.state   = acs_pkg::ACS_CONVERT;
                    s_d.tmr     = acs_pkg::TMR_ZERO;
                    s_d.conv_on = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            // settings only change here and on an accepted word
            s_q <= '{state:     acs_pkg::ACS_POR,
                     tmr:       acs_pkg::TMR_ZERO,
                     result:    '0,
                     rate_fast: 1'b0,
                     sleep_en:  1'b0,
                     conv_on:   1'b0,
                     ref_on:    1'b1,
                     cs_prev:   1'b1,
                     done_prev: 1'b0,
                     word_prev: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign converter_on = s_q.conv_on;
    assign reference_on = s_q.ref_on;
    assign conv_busy    = s_q.conv_on;
    assign rate_fast    = s_q.rate_fast;
    assign ref_sleep_en = s_q.sleep_en;

endmodule

// File: dv/acs_ctrl_sva.sv
/*
 * Checker for acs_ctrl: power sequencing, conversion length, output enable.
 * Assumes chip select falls only outside a conversion.
 */
`timescale 1ns/1ps

module acs_ctrl_sva #(
    parameter int unsigned CONV_SLOW_CYC = 40,
    parameter int unsigned CONV_FAST_CYC = 10,
    parameter int unsigned POR_CYC       = 8
) (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic [15:0] result_in,
    input wire logic        sck,
    input wire logic        chip_sel_n,
    input wire logic        sdi,
    input wire logic        sdo,
    input wire logic        sdo_oe_n,
    input wire logic        converter_on,
    input wire logic        reference_on,
    input wire logic        conv_busy,
    input wire logic        rate_fast,
    input wire logic        ref_sleep_en
);
    // ------------------------------------------------------------------
    // conversion length counter
    // ------------------------------------------------------------------
    logic [16:0] len_q;
    logic [16:0] len_d;
    always_comb len_d = converter_on ? len_q + 17'h00001 : 17'h00000;
    always_ff @(posedge ref_clk) len_q <= sys_rst ? 17'h00000 : len_d;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    a_out_enable: assert property (sdo_oe_n == chip_sel_n)
        else $error("output enable differs from chip select");
    a_conv_len: assert property ($fell(converter_on) |->
        len_q == 17'(rate_fast ? CONV_FAST_CYC : CONV_SLOW_CYC))
        else $error("conversion length wrong");
    a_busy_power: assert property (conv_busy == converter_on)
        else $error("busy and converter power differ");
    a_ref_in_conv: assert property (converter_on |-> reference_on)
        else $error("converting without reference");
    a_sleep_after: assert property ($fell(converter_on) |->
        reference_on == !ref_sleep_en)
        else $error("reference power wrong after conversion");
    a_ref_wake: assert property ($fell(chip_sel_n) |-> ##[1:4] reference_on)
        else $error("reference not powered after chip select low");
    a_abort_start: assert property ($rose(chip_sel_n) && !converter_on |->
        ##[1:4] converter_on)
        else $error("abort did not start a conversion");
    a_set_hold: assert property (converter_on && $past(converter_on) |->
        $stable(rate_fast) && $stable(ref_sleep_en))
        else $error("settings changed during conversion");
    // literal 8 matches the bench's POR_CYC
    a_por_wait: assert property ($fell(sys_rst) |-> !converter_on [*8] ##[1:4] converter_on)
        else $error("power-on delay wrong");
    a_reset_clear: assert property (disable iff (1'b0) sys_rst |=>
        !converter_on && reference_on && !rate_fast && !ref_sleep_en)
        else $error("reset values wrong");

    c_fast: cover property ($fell(converter_on) && rate_fast);
    c_sleep: cover property ($fell(converter_on) && ref_sleep_en);
    c_abort: cover property ($rose(chip_sel_n) && !converter_on);
endmodule

bind acs_ctrl acs_ctrl_sva #(
    .CONV_SLOW_CYC(CONV_SLOW_CYC),
    .CONV_FAST_CYC(CONV_FAST_CYC),
    .POR_CYC      (POR_CYC)
) u_sva (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .result_in   (result_in),
    .sck         (sck),
    .chip_sel_n  (chip_sel_n),
    .sdi         (sdi),
    .sdo         (sdo),
    .sdo_oe_n    (sdo_oe_n),
    .converter_on(converter_on),
    .reference_on(reference_on),
    .conv_busy   (conv_busy),
    .rate_fast   (rate_fast),
    .ref_sleep_en(ref_sleep_en)
);

// File: dv/acs_host.sv
/*
 * Serial host model: drives chip select, clock and data in, captures data out.
 * Assumes the caller only opens a frame after a conversion has finished.
 */
`timescale 1ns/1ps

module acs_host (
    output logic        sck,
    output logic        chip_sel_n,
    output logic        sdi,
    output logic        rx_stb,
    output logic [15:0] rx_data,
    input  wire logic   sdo
);
    initial begin
        sck = 1'b0;
        chip_sel_n = 1'b1;
        sdi = 1'b0;
        rx_stb = 1'b0;
        rx_data = 16'h0000;
    end

    // clock stands low between frames; 32 ns period within them
    task automatic xfer(input logic [15:0] bits, input int nb);
        chip_sel_n = 1'b0;
        #200;
        for (int i = 0; i < nb; i++) begin
            sdi = bits[15-i];
            #16 sck = 1'b1;
            rx_data = {rx_data[14:0], sdo};
            #16 sck = 1'b0;
        end
        #200 chip_sel_n = 1'b1;
        sdi = ~sdi;
        if (nb == 16) begin
            rx_stb = 1'b1;
            #1 rx_stb = 1'b0;
        end
    endtask
endmodule

// File: dv/acs_ctrl_test.sv
/*
 * Self-checking bench for acs_ctrl with shortened counts.
 * Assumes the host model in acs_host.sv and the bound checker.
 */
`timescale 1ns/1ps

module acs_ctrl_test;
    logic        ref_clk;
    logic        sys_rst;
    logic [15:0] result_in;
    logic [15:0] rx_data;
    logic [15:0] last_res;
    logic        sck, chip_sel_n, sdi, rx_stb, sdo, sdo_oe_n;
    logic        converter_on, reference_on, conv_busy, rate_fast, ref_sleep_en;
    logic        r, s;
    logic [15:0] exp_q[$];
    logic [3:0]  words[6] = '{4'ha, 4'h6, 4'h9, 4'hf, 4'hb, 4'h0};
    int          bad_count, cmp_count, seed;

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    acs_ctrl #(.CONV_SLOW_CYC(40), .CONV_FAST_CYC(10), .POR_CYC(8)) u_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .result_in(result_in), .sck(sck),
        .chip_sel_n(chip_sel_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .converter_on(converter_on), .reference_on(reference_on),
        .conv_busy(conv_busy), .rate_fast(rate_fast), .ref_sleep_en(ref_sleep_en));

    acs_host u_host (.sck(sck), .chip_sel_n(chip_sel_n), .sdi(sdi), .rx_stb(rx_stb),
        .rx_data(rx_data), .sdo(sdo));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (bad_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic conv();
        int n;
        n = 0;
        while (converter_on !== 1'b1 && n < 3000) begin @(negedge ref_clk); n++; end
        while (converter_on !== 1'b0 && n < 3000) begin @(negedge ref_clk); n++; end
        if (n >= 3000) bad_count++;
        check("reference after conversion", reference_on, !s);
    endtask

    task automatic frame(input logic [3:0] w, input int nb);
        if (nb >= 4 && w[3:2] == 2'b10) {r, s} = w[1:0];
        else if (nb >= 4 && (w == 4'h0 || w == 4'hf)) {r, s} = {w[0], 1'b0};
        if (nb == 16) exp_q.push_back(last_res);
        result_in = 16'($random(seed));
        last_res = result_in;
        u_host.xfer({w, 12'($random(seed))}, nb);
        @(negedge ref_clk);
        check("rate", rate_fast, r);
        check("sleep enable", ref_sleep_en, s);
        check("reference awake", reference_on, 1'b1);
        conv();
    endtask

    always @(posedge rx_stb) begin
        if (exp_q.size() == 0) check("frame count", 16'h0001, 16'h0000);
        else check("result", rx_data, exp_q.pop_front());
    end

    initial begin
        #300000;
        bad_count++;
        close_out();
    end

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 8930;
        sys_rst = 1'b1;
        result_in = 16'h0000;
        last_res = 16'h0000;
        {r, s} = 2'b00;
        repeat (20) @(negedge ref_clk);
        check("reset state", {rate_fast, ref_sleep_en, reference_on}, 3'h1);
        check("output enable", sdo_oe_n, 1'b1);
        sys_rst = 1'b0;
        conv();
        frame(4'ha, 3);
        foreach (words[i]) frame(words[i], 16);
        frame(4'ha, 16);
        result_in = 16'($random(seed));
        last_res = result_in;
        // empty frame: chip select low then high starts a conversion
        u_host.xfer(16'h0000, 0);
        repeat (5) @(negedge ref_clk);
        check("busy", conv_busy, 1'b1);
        sys_rst = 1'b1;
        repeat (20) @(negedge ref_clk);
        {r, s} = 2'b00;
        check("rate after reset", rate_fast, 1'b0);
        sys_rst = 1'b0;
        conv();
        frame(4'h0, 16);
        repeat (5) @(negedge ref_clk);
        check("pending results", 16'(exp_q.size()), 16'h0000);
        close_out();
    end
endmodule
